// file: core/tzp_pwm.sv
// Timer-zero pwm unit: counter, double-buffered duty, pin mux, request flag.
// Assumes a one-clock register port with read data one cycle after the strobe.
// Behaviour
// - The counter wraps after 256, 64, 32 or 16 counts as the two range bits select.
// - Counter and duty values are limited to the selected range; one overflow per modulus.
// - The output goes low when the counter equals the active duty value.
// - The output goes high when the counter wraps to zero with a nonzero new duty value.
// - Output is high while counter is below the duty value and low otherwise.
// - High time over a period equals duty divided by the modulus.
// - A duty of zero keeps the output low.
// - Duty writes go to a buffer and reach the compare only at overflow.
// - A new duty takes effect from the next period; no double toggle in a period.
// - The request flag is set on every counter overflow.
// - Pwm operation and the interrupt request work together.
// - With output enable set, the pin carries the pwm and general I/O is cut off.
// - The counter clock is fcpu divided per the rate field, 110 giving divide by four.
`timescale 1ns/100ps
module tzp_pwm (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [tzp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tzp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tzp_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic gpio_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe
);
  import tzp_pkg::*;

  logic timer_enable_bit;
  logic range_select_low;
  logic range_select_high;
  logic pulse_out_enable;
  logic [RATE_W-1:0] clock_rate_field;
  logic [CNT_W-1:0] duty_reference;
  logic [CNT_W-1:0] active_duty;
  logic [CNT_W-1:0] pwm_counter;
  logic pwm_level;
  logic timer_request_flag;
  logic request_mask;
  logic tick;
  logic [CNT_W-1:0] range_mask;
  logic wrap;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_duty;
  logic wr_ctrl;
  logic wr_duty;
  logic wr_count;
  logic wr_status;
  logic wr_mask;

  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_duty = reg_wr && (reg_addr == OFS_DUTY);
  assign wr_count = reg_wr && (reg_addr == OFS_COUNT);
  assign wr_status = reg_wr && (reg_addr == OFS_STATUS);
  assign wr_mask = reg_wr && (reg_addr == OFS_MASK);

  always_comb begin
    case (tzp_range_t'({range_select_high, range_select_low}))
      TZP_RANGE_256: range_mask = MASK_256;
      TZP_RANGE_64: range_mask = MASK_64;
      TZP_RANGE_32: range_mask = MASK_32;
      TZP_RANGE_16: range_mask = MASK_16;
      default: range_mask = MASK_256;
    endcase
  end

  tzp_prescaler #(
    .PRE_W(PRE_W)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(timer_enable_bit),
    .rate(clock_rate_field),
    .tick(tick)
  );

  // Overflow when the masked count reaches the top of the range
  assign wrap = tick && ((pwm_counter & range_mask) == range_mask);
  assign next_count = wrap ? CNT_RESET : ((pwm_counter + CNT_W'(1)) & range_mask);
  assign next_duty = duty_reference & range_mask;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_enable_bit <= 1'b0;
      range_select_low <= 1'b0;
      range_select_high <= 1'b0;
      pulse_out_enable <= 1'b0;
      clock_rate_field <= RATE_RESET;
    end else if (wr_ctrl) begin
      timer_enable_bit <= reg_wdata[CTRL_ENABLE_BIT];
      range_select_low <= reg_wdata[CTRL_RANGE_LOW_BIT];
      range_select_high <= reg_wdata[CTRL_RANGE_HIGH_BIT];
      pulse_out_enable <= reg_wdata[CTRL_OUT_ENABLE_BIT];
      clock_rate_field <= reg_wdata[CTRL_RATE_LSB +: RATE_W];
    end
  end

  // Write-only buffer; may be written at any time without glitching the pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_reference <= DUTY_RESET;
    end else if (wr_duty) begin
      duty_reference <= reg_wdata[CNT_W-1:0];
    end
  end

  // Active compare only moves at overflow, so each period keeps one duty
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_duty <= DUTY_RESET;
    end else if (wrap) begin
      active_duty <= next_duty;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_counter <= CNT_RESET;
    end else if (wr_count) begin
      pwm_counter <= reg_wdata[CNT_W-1:0] & range_mask;
    end else if (tick) begin
      pwm_counter <= next_count;
    end
  end

  // Level follows counter < duty; at wrap uses the freshly loaded duty
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_level <= 1'b0;
    end else if (wr_count) begin
      // Count write wins over a wrap in the same cycle, so compare with the duty in force
      pwm_level <= ((reg_wdata[CNT_W-1:0] & range_mask)
                    < (wrap ? next_duty : active_duty));
    end else if (wrap) begin
      pwm_level <= (next_duty != CNT_RESET);
    end else if (tick) begin
      // Equality drops the level; below stays high; at or above stays low
      pwm_level <= (next_count < active_duty);
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_request_flag <= 1'b0;
    end else if (wrap) begin
      timer_request_flag <= 1'b1;
    end else if (wr_status && reg_wdata[STAT_REQUEST_BIT]) begin
      timer_request_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      request_mask <= 1'b0;
    end else if (wr_mask) begin
      request_mask <= reg_wdata[STAT_REQUEST_BIT];
    end
  end

  assign irq = timer_request_flag && request_mask;

  // Pin mux: pwm owns the pin while enabled
  assign pin_out = pulse_out_enable ? pwm_level : gpio_out;
  assign pin_oe = pulse_out_enable ? 1'b1 : gpio_oe;
  assign gpio_in = pulse_out_enable ? 1'b0 : pin_in;

  // Duty reads as zero: it is write-only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: begin
          reg_rdata <= '0;
          reg_rdata[CTRL_ENABLE_BIT] <= timer_enable_bit;
          reg_rdata[CTRL_RANGE_LOW_BIT] <= range_select_low;
          reg_rdata[CTRL_RANGE_HIGH_BIT] <= range_select_high;
          reg_rdata[CTRL_OUT_ENABLE_BIT] <= pulse_out_enable;
          reg_rdata[CTRL_RATE_LSB +: RATE_W] <= clock_rate_field;
        end
        // Stale high bits after a range change never show
        OFS_COUNT: reg_rdata <= {{(DATA_W-CNT_W){1'b0}}, pwm_counter & range_mask};
        OFS_STATUS: reg_rdata <= {{(DATA_W-1){1'b0}}, timer_request_flag};
        OFS_MASK: reg_rdata <= {{(DATA_W-1){1'b0}}, request_mask};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : tzp_pwm

// file: core/tzp_pkg.sv
// Shared constants for the timer-zero pwm unit.
// Assumes a single 100 MHz system clock and a plain strobe register port.
package tzp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int RATE_W = 3;
  localparam int PRE_W = 8;

  // Register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DUTY = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;

  // Control register field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RANGE_LOW_BIT = 1;
  localparam int CTRL_RANGE_HIGH_BIT = 2;
  localparam int CTRL_OUT_ENABLE_BIT = 3;
  localparam int CTRL_RATE_LSB = 4;

  // Status and mask field positions
  localparam int STAT_REQUEST_BIT = 0;

  // Values after reset
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] DUTY_RESET = 8'h00;
  localparam logic [RATE_W-1:0] RATE_RESET = 3'h0;

  // Range select codes {high, low} and their count masks
  typedef enum logic [1:0] {
    TZP_RANGE_256 = 2'b00,
    TZP_RANGE_64 = 2'b01,
    TZP_RANGE_32 = 2'b10,
    TZP_RANGE_16 = 2'b11
  } tzp_range_t;

  localparam logic [CNT_W-1:0] MASK_256 = 8'hff;
  localparam logic [CNT_W-1:0] MASK_64 = 8'h3f;
  localparam logic [CNT_W-1:0] MASK_32 = 8'h1f;
  localparam logic [CNT_W-1:0] MASK_16 = 8'h0f;

  // Rate code for divide by four, as used in typical setups
  localparam logic [RATE_W-1:0] RATE_DIV4 = 3'h6;
endpackage : tzp_pkg

// file: core/tzp_prescaler.sv
// Prescaler: one-cycle tick at fcpu / 2^(8 - rate).
// Assumes rate is steady while counting; a change only shifts one period.
`timescale 1ns/100ps
module tzp_prescaler #(
  parameter int PRE_W = tzp_pkg::PRE_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [tzp_pkg::RATE_W-1:0] rate,
  output logic tick
);
  import tzp_pkg::*;

  logic [PRE_W-1:0] div_cnt;
  logic [PRE_W-1:0] low_mask;

  // Rate 000 divides by 256, 110 by 4, 111 by 2
  assign low_mask = PRE_W'({PRE_W{1'b1}} >> rate);
  assign tick = run && ((div_cnt & low_mask) == low_mask);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (run) begin
      div_cnt <= div_cnt + PRE_W'(1);
    end else begin
      div_cnt <= '0;
    end
  end
endmodule : tzp_prescaler

// file: tb/tzp_load.sv
// Load model on the pwm pin.
// Assumes the unit drives pin_out only while pin_oe is high.
`timescale 1ns/100ps
module tzp_load (
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_in
);
  // Released pin goes to the pull-up level
  assign pin_in = pin_oe ? pin_out : 1'b1;
endmodule : tzp_load

// file: tb/tzp_pwm_sva.sv
// Checker on the ports of the pwm unit.
// Assumes one clock domain and the tzp_pkg register map.
`timescale 1ns/100ps
module tzp_pwm_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [tzp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tzp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tzp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic gpio_in,
  input wire logic pin_in,
  input wire logic pin_out,
  input wire logic pin_oe
);
  import tzp_pkg::*;
  logic [6:0] ctl;
  logic msk;
  // Shadow of control and mask, updated on the same edge as the unit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= '0;
      msk <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL) ctl <= reg_wdata[6:0];
      if (reg_addr == OFS_MASK) msk <= reg_wdata[0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_DUTY_WO: assert property (reg_rd && reg_addr == OFS_DUTY |=> reg_rdata == '0)
    else $error("duty read not zero");
  AST_PIN_PWM: assert property (ctl[3] |-> pin_oe && !gpio_in)
    else $error("pin not taken by pwm");
  AST_PIN_GPIO: assert property (
    !ctl[3] |-> pin_oe == gpio_oe && pin_out == gpio_out)
    else $error("pin not given to gpio");
  AST_IRQ_MASK: assert property (!msk |-> !irq)
    else $error("irq while masked");
  AST_CLEAR_IRQ: assert property (
    reg_wr && reg_addr == OFS_STATUS && reg_wdata[0] && !ctl[0] |=> !irq)
    else $error("irq after clear");
  AST_RANGE_16: assert property (
    reg_rd && reg_addr == OFS_COUNT && ctl[2:1] == 2'b11 |=> reg_rdata[31:4] == '0)
    else $error("count out of range");
  AST_HOLD: assert property (!ctl[0] && ctl[3] && !reg_wr |=> $stable(pin_out))
    else $error("pin moved while stopped");
  AST_DIV4: assert property (
    ctl == 7'h6f && $changed(pin_out) && !$past(reg_wr)
    |=> ($stable(pin_out) || ctl != 7'h6f)[*3])
    else $error("step faster than four");
  COV_IRQ: cover property ($rose(irq));
  COV_LOW: cover property (ctl[3] && $fell(pin_out));
  COV_CLR: cover property (reg_wr && reg_addr == OFS_STATUS);
endmodule : tzp_pwm_sva
bind tzp_pwm tzp_pwm_sva CHK (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .irq, .gpio_out, .gpio_oe, .gpio_in, .pin_in, .pin_out, .pin_oe);

// file: tb/tb_top.sv
// Testbench: register tasks and pwm timing scenarios.
// Assumes the unit, load model and checker are compiled first.
`timescale 1ns/100ps
module tb_top;
  import tzp_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, irq, gpio_in, pin_in, pin_out, pin_oe;
  logic gpio_out = 1'b0;
  logic gpio_oe = 1'b0;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  int err_count = 0, checks = 0, cyc = 0, h, m;
  tzp_pwm DUT (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .gpio_out, .gpio_oe, .gpio_in, .pin_in, .pin_out, .pin_oe);
  tzp_load LOAD (.pin_out, .pin_oe, .pin_in);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    gpio_out <= ~gpio_out;
    gpio_oe <= gpio_out;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, e);
  endtask : rd
  // Wait for a low-to-high step of the pin, bounded
  task automatic sync();
    logic p;
    p = 1'b1;
    for (int k = 0; k < 2000; k++) begin
      @(negedge clk_sys);
      if (p === 1'b0 && pin_out === 1'b1) return;
      p = pin_out;
    end
    chk(0, 1);
  endtask : sync
  task automatic meas(input int n, input int e);
    h = 0;
    repeat (n) begin
      @(negedge clk_sys);
      h += int'(pin_out === 1'b1);
    end
    chk(32'(h), 32'(e));
  endtask : meas
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial begin
    {rst_n, reg_wr, reg_rd} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(8'h14, 32'hff);
    for (int a = 0; a < 24; a += 4) rd(8'(a), 0);
    // Port owns the pin: pull-up shows whenever the port does not drive
    repeat (2) begin
      @(negedge clk_sys);
      chk(32'(gpio_in), 32'(gpio_oe ? gpio_out : 1'b1));
    end
    $display("test 1 done");
    for (int r = 0; r < 4; r++) begin
      m = r == 0 ? 256 : 128 >> r;
      // Duty bits above the range set on purpose in the 64, 32 and 16 ranges: they must be masked off
      wr(OFS_DUTY, 32'((m / 4 + 1) | (256 - m)));
      wr(OFS_COUNT, 0);
      wr(OFS_CTRL, 32'(32'h79 | (r << 1)));
      sync();
      meas(2 * m, 2 * (m / 4 + 1));
      rd(OFS_STATUS, 1);
      wr(OFS_CTRL, 0);
      wr(OFS_STATUS, 1);
    end
    $display("test 2 done");
    wr(OFS_DUTY, 5);
    wr(OFS_CTRL, 32'h7f);
    sync();
    wr(OFS_DUTY, 0);
    meas(62, 8);
    meas(64, 0);
    $display("test 3 done");
    wr(OFS_MASK, 1);
    repeat (40) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(irq), 1);
    wr(OFS_CTRL, 32'h0e);
    wr(OFS_STATUS, 1);
    rd(OFS_STATUS, 0);
    rd(OFS_CTRL, 32'h0e);
    rd(OFS_MASK, 1);
    wr(OFS_COUNT, 32'h39);
    repeat (20) @(posedge clk_sys);
    rd(OFS_COUNT, 9);
    $display("test 4 done");
    wr(OFS_DUTY, 8);
    wr(OFS_CTRL, 32'h6f);
    sync();
    meas(64, 32);
    chk(32'(gpio_in), 0);
    $display("test 5 done");
    // Reset in mid-run hands the pin back and drops the pending request
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_CTRL, 0);
    rd(OFS_STATUS, 0);
    chk(32'(irq), 0);
    chk(32'(pin_oe), 32'(gpio_oe));
    $display("test 6 done");
    end_of_test();
  end
endmodule : tb_top
